// ---- rtl/dot_defs.svh ----
// timing counts and constants for the termination control link
`ifndef DOT_DEFS_SVH
`define DOT_DEFS_SVH

`define DOT_CLK_PERIOD_PS 5000
`define DOT_ASYNC_MIN_PS 2000
`define DOT_ASYNC_MAX_PS 8500
`define DOT_ASYNC_MIN_CYC (((`DOT_ASYNC_MIN_PS + `DOT_CLK_PERIOD_PS - 1) / `DOT_CLK_PERIOD_PS) < 1 ? 1 : ((`DOT_ASYNC_MIN_PS + `DOT_CLK_PERIOD_PS - 1) / `DOT_CLK_PERIOD_PS))
`define DOT_ASYNC_MAX_CYC ((`DOT_ASYNC_MAX_PS / `DOT_CLK_PERIOD_PS) < 1 ? 1 : (`DOT_ASYNC_MAX_PS / `DOT_CLK_PERIOD_PS))
`define DOT_WRLAT_W 5
`define DOT_CNT_W 8
`define DOT_PIPE_DEPTH 32
`define DOT_HOLD_ASSERT_CYC 8'h04
`define DOT_HOLD_BL8_CYC 8'h06
`define DOT_HOLD_BC4_CYC 8'h04
`define DOT_SYNC_LAT_OFS 5'h02
`define DOT_ANPD_OFS 5'h01
`define DOT_CPDED_CYC 8'h01
`define DOT_RFC_CYC 8'h40

`endif

// ---- rtl/dot_pkg.sv ----
// command type shared by both ends of the termination control link, plus each end's own state type
package dot_pkg;
    typedef enum logic [2:0] {
        DOT_CMD_NOP,
        DOT_CMD_DESELECT,
        DOT_CMD_WRITE_BL8,
        DOT_CMD_WRITE_BC4,
        DOT_CMD_READ,
        DOT_CMD_REFRESH
    } dot_cmd_type;

    typedef enum logic [2:0] {
        DOT_DEV_ACTIVE,
        DOT_DEV_ENTRY,
        DOT_DEV_PD_ASYNC,
        DOT_DEV_PD_SYNC,
        DOT_DEV_EXIT
    } dot_dev_state_type;

    typedef enum logic [1:0] {
        DOT_CTL_RUN,
        DOT_CTL_PREP,
        DOT_CTL_ENTRY,
        DOT_CTL_PD
    } dot_ctl_state_type;
endpackage

// ---- rtl/dot_link_if.sv ----
// link between memory controller and memory device termination logic
`timescale 1ns/1ps
interface dot_link_if;
    logic odt;
    logic cke;
    dot_pkg::dot_cmd_type cmd;
    logic term_on;

    modport dev (
        input odt,
        input cke,
        input cmd,
        output term_on
    );

    modport ctl (
        output odt,
        output cke,
        output cmd,
        input term_on
    );
endinterface

// ---- rtl/dot_device.sv ----
// memory device end: synchronous, asynchronous and transition termination response
`timescale 1ns/1ps
`include "dot_defs.svh"
module dot_device (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic ppd_dll_on,
    input wire logic [`DOT_WRLAT_W-1:0] write_latency,
    dot_link_if.dev link,
    output logic term_uncertain,
    output logic async_mode,
    output logic in_powerdown,
    output logic hold_err
);
    logic cke_q;
    logic [`DOT_PIPE_DEPTH-1:0] pipe_q;
    logic [`DOT_CNT_W-1:0] rfc_q;
    logic [`DOT_CNT_W-1:0] wait_q;
    logic [`DOT_CNT_W-1:0] wait_d;
    logic [`DOT_CNT_W-1:0] need_q;
    logic [`DOT_CNT_W-1:0] need_dec;
    logic [`DOT_CNT_W-1:0] need_wr;
    logic [`DOT_WRLAT_W-1:0] sync_idx;
    logic [`DOT_CNT_W-1:0] sync_lat;
    logic cke_fall;
    logic cmd_live;
    logic odt_rise;
    logic odt_fall;
    logic wr_bl8;
    logic wr_bc4;
    logic term_d;
    logic term_q;
    logic uncertain_q;
    logic async_q;
    logic pd_q;
    logic hold_err_q;
    dot_pkg::dot_dev_state_type state_q;
    dot_pkg::dot_dev_state_type state_d;

    // a registered fall of cke marks the first power-down cycle
    assign cke_fall = cke_q & ~link.cke;
    // command receivers are only trusted while cke stays high on both edges
    assign cmd_live = cke_q & link.cke;
    assign odt_rise = link.odt & ~pipe_q[0];
    assign odt_fall = ~link.odt & pipe_q[0];
    assign wr_bl8 = cmd_live && link.cmd == dot_pkg::DOT_CMD_WRITE_BL8 && link.odt;
    assign wr_bc4 = cmd_live && link.cmd == dot_pkg::DOT_CMD_WRITE_BC4 && link.odt;
    // sync latency is write latency minus two; index is one less
    assign sync_lat = `DOT_CNT_W'(write_latency - `DOT_SYNC_LAT_OFS);
    assign sync_idx = `DOT_WRLAT_W'(write_latency - `DOT_SYNC_LAT_OFS - 5'h01);
    assign need_dec = (need_q != 8'h00) ? need_q - 8'h01 : 8'h00;
    assign need_wr = wr_bl8 ? `DOT_HOLD_BL8_CYC - 8'h01 : `DOT_HOLD_BC4_CYC - 8'h01;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cke_q <= 1'b0;
        end else if (ce) begin
            cke_q <= link.cke;
        end
    end

    // odt is sampled every cycle, power-down or not
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pipe_q <= '0;
        end else if (ce) begin
            pipe_q <= {pipe_q[`DOT_PIPE_DEPTH-2:0], link.odt};
        end
    end

    // refresh in progress, counted down in clock cycles over one refresh cycle time of 64 cycles
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rfc_q <= 8'h00;
        end else if (ce) begin
            if (cmd_live && link.cmd == dot_pkg::DOT_CMD_REFRESH) begin
                rfc_q <= `DOT_RFC_CYC;
            end else if (rfc_q != 8'h00) begin
                rfc_q <= rfc_q - 8'h01;
            end
        end
    end

    always_comb begin
        state_d = state_q;
        wait_d = wait_q;
        case (state_q)
            dot_pkg::DOT_DEV_ACTIVE: begin
                if (cke_fall) begin
                    if (!ppd_dll_on) begin
                        state_d = dot_pkg::DOT_DEV_ENTRY;
                        wait_d = `DOT_CPDED_CYC;
                    end else begin
                        state_d = dot_pkg::DOT_DEV_PD_SYNC;
                    end
                end
            end
            dot_pkg::DOT_DEV_ENTRY: begin
                if (link.cke) begin
                    state_d = dot_pkg::DOT_DEV_EXIT;
                    wait_d = sync_lat;
                end else if (wait_q == 8'h00 && rfc_q == 8'h00) begin
                    // both end points were spent inside the window
                    state_d = dot_pkg::DOT_DEV_PD_ASYNC;
                end else if (wait_q != 8'h00) begin
                    wait_d = wait_q - 8'h01;
                end
            end
            dot_pkg::DOT_DEV_PD_ASYNC: begin
                if (link.cke) begin
                    // stay async until the sync pipe holds current odt history
                    state_d = dot_pkg::DOT_DEV_EXIT;
                    wait_d = sync_lat;
                end
            end
            dot_pkg::DOT_DEV_EXIT: begin
                if (!link.cke) begin
                    state_d = dot_pkg::DOT_DEV_PD_ASYNC;
                end else if (wait_q == 8'h00) begin
                    state_d = dot_pkg::DOT_DEV_ACTIVE;
                end else begin
                    wait_d = wait_q - 8'h01;
                end
            end
            dot_pkg::DOT_DEV_PD_SYNC: begin
                if (link.cke) begin
                    state_d = dot_pkg::DOT_DEV_ACTIVE;
                end
            end
            default: begin
                state_d = dot_pkg::DOT_DEV_ACTIVE;
                wait_d = 8'h00;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= dot_pkg::DOT_DEV_ACTIVE;
            wait_q <= 8'h00;
        end else if (ce) begin
            state_q <= state_d;
            wait_q <= wait_d;
        end
    end

    // termination response selection
    always_comb begin
        case (state_q)
            dot_pkg::DOT_DEV_PD_ASYNC, dot_pkg::DOT_DEV_EXIT: begin
                // additive latency plays no part here
                term_d = pipe_q[`DOT_ASYNC_MAX_CYC-1];
            end
            dot_pkg::DOT_DEV_ENTRY: begin
                // sync answer stays inside the combined window; pending
                // changes land early at the switch, never past sync latency
                term_d = pipe_q[sync_idx];
            end
            default: begin
                term_d = pipe_q[sync_idx];
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            term_q <= 1'b0;
            uncertain_q <= 1'b0;
            async_q <= 1'b0;
            pd_q <= 1'b0;
        end else if (ce) begin
            term_q <= term_d;
            uncertain_q <= (state_d == dot_pkg::DOT_DEV_ENTRY);
            async_q <= (state_d == dot_pkg::DOT_DEV_PD_ASYNC) || (state_d == dot_pkg::DOT_DEV_EXIT);
            pd_q <= ~link.cke;
        end
    end

    // minimum odt high time checker, one-cycle error pulse on violation
    always_ff @(posedge core_clk) begin
        if (rst) begin
            need_q <= 8'h00;
            hold_err_q <= 1'b0;
        end else if (ce) begin
            hold_err_q <= odt_fall && need_q != 8'h00;
            // a write on the rising edge must win, else an eight-beat write's longer hold is lost
            if (wr_bl8 || wr_bc4) begin
                need_q <= (need_wr > need_dec) ? need_wr : need_dec;
            end else if (odt_rise) begin
                need_q <= `DOT_HOLD_ASSERT_CYC - 8'h01;
            end else begin
                need_q <= need_dec;
            end
        end
    end

    assign link.term_on = term_q;
    assign term_uncertain = uncertain_q;
    assign async_mode = async_q;
    assign in_powerdown = pd_q;
    assign hold_err = hold_err_q;
endmodule

// ---- rtl/dot_controller.sv ----
// controller end: drives odt, cke and commands with hold and power-down sequencing
`timescale 1ns/1ps
`include "dot_defs.svh"
module dot_controller (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [`DOT_WRLAT_W-1:0] write_latency,
    dot_link_if.ctl link,
    input wire logic odt_req,
    input wire logic wr_req,
    input wire logic wr_bc4,
    input wire logic rd_req,
    input wire logic ref_req,
    input wire logic pd_req,
    output logic cmd_taken,
    output logic cmd_refused,
    output logic term_settled,
    output logic in_pd
);
    logic odt_q;
    logic odt_d;
    logic cke_q;
    dot_pkg::dot_cmd_type cmd_q;
    dot_pkg::dot_cmd_type cmd_d;
    logic [`DOT_CNT_W-1:0] hold_q;
    logic [`DOT_CNT_W-1:0] hold_dec;
    logic [`DOT_CNT_W-1:0] hold_wr;
    logic [`DOT_CNT_W-1:0] rfc_q;
    logic [`DOT_CNT_W-1:0] cnt_q;
    logic [`DOT_CNT_W-1:0] settle_q;
    logic taken_q;
    logic refused_q;
    logic settled_q;
    logic pd_q;
    logic any_req;
    dot_pkg::dot_ctl_state_type state_q;

    assign any_req = wr_req | rd_req | ref_req;
    // commands only go out while running with cke high
    always_comb begin
        cmd_d = dot_pkg::DOT_CMD_NOP;
        if (state_q == dot_pkg::DOT_CTL_RUN && !pd_req) begin
            if (wr_req) begin
                cmd_d = wr_bc4 ? dot_pkg::DOT_CMD_WRITE_BC4 : dot_pkg::DOT_CMD_WRITE_BL8;
            end else if (rd_req) begin
                cmd_d = dot_pkg::DOT_CMD_READ;
            end else if (ref_req) begin
                cmd_d = dot_pkg::DOT_CMD_REFRESH;
            end
        end
    end

    // odt may only drop once every pending hold has run out
    assign odt_d = odt_req | (odt_q & hold_q != 8'h00);
    assign hold_dec = (hold_q != 8'h00) ? hold_q - 8'h01 : 8'h00;
    assign hold_wr = (cmd_d == dot_pkg::DOT_CMD_WRITE_BC4) ? `DOT_HOLD_BC4_CYC - 8'h01 : `DOT_HOLD_BL8_CYC - 8'h01;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            odt_q <= 1'b0;
            hold_q <= 8'h00;
        end else if (ce) begin
            odt_q <= odt_d;
            if (odt_d && (cmd_d == dot_pkg::DOT_CMD_WRITE_BL8 || cmd_d == dot_pkg::DOT_CMD_WRITE_BC4)) begin
                hold_q <= (hold_wr > hold_dec) ? hold_wr : hold_dec;
            end else if (odt_d && !odt_q) begin
                hold_q <= `DOT_HOLD_ASSERT_CYC - 8'h01;
            end else begin
                hold_q <= hold_dec;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cmd_q <= dot_pkg::DOT_CMD_NOP;
            taken_q <= 1'b0;
            refused_q <= 1'b0;
            rfc_q <= 8'h00;
        end else if (ce) begin
            cmd_q <= cmd_d;
            taken_q <= cmd_d != dot_pkg::DOT_CMD_NOP;
            // no read or write reaches a powered-down device
            refused_q <= any_req && cmd_d == dot_pkg::DOT_CMD_NOP;
            if (cmd_d == dot_pkg::DOT_CMD_REFRESH) begin
                rfc_q <= `DOT_RFC_CYC;
            end else if (rfc_q != 8'h00) begin
                rfc_q <= rfc_q - 8'h01;
            end
        end
    end

    // power-down sequencing; the prep phase covers the backward window
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= dot_pkg::DOT_CTL_RUN;
            cke_q <= 1'b0;
            cnt_q <= 8'h00;
        end else if (ce) begin
            case (state_q)
                dot_pkg::DOT_CTL_RUN: begin
                    cke_q <= 1'b1;
                    if (pd_req && cke_q) begin
                        state_q <= dot_pkg::DOT_CTL_PREP;
                        cnt_q <= `DOT_CNT_W'(write_latency - `DOT_ANPD_OFS);
                    end
                end
                dot_pkg::DOT_CTL_PREP: begin
                    if (!pd_req) begin
                        state_q <= dot_pkg::DOT_CTL_RUN;
                    end else if (cnt_q <= 8'h01) begin
                        cke_q <= 1'b0;
                        state_q <= dot_pkg::DOT_CTL_ENTRY;
                        cnt_q <= (rfc_q > `DOT_CPDED_CYC) ? rfc_q : `DOT_CPDED_CYC;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                dot_pkg::DOT_CTL_ENTRY: begin
                    if (!pd_req) begin
                        cke_q <= 1'b1;
                        state_q <= dot_pkg::DOT_CTL_RUN;
                    end else if (cnt_q == 8'h00) begin
                        state_q <= dot_pkg::DOT_CTL_PD;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                dot_pkg::DOT_CTL_PD: begin
                    if (!pd_req) begin
                        cke_q <= 1'b1;
                        state_q <= dot_pkg::DOT_CTL_RUN;
                    end
                end
                default: begin
                    state_q <= dot_pkg::DOT_CTL_RUN;
                end
            endcase
        end
    end

    // settled only after the widest turn-on or turn-off window has passed
    always_ff @(posedge core_clk) begin
        if (rst) begin
            settle_q <= 8'h00;
            settled_q <= 1'b0;
            pd_q <= 1'b0;
        end else if (ce) begin
            if (odt_d != odt_q || state_q != dot_pkg::DOT_CTL_RUN) begin
                settle_q <= `DOT_CNT_W'(write_latency);
            end else if (settle_q != 8'h00) begin
                settle_q <= settle_q - 8'h01;
            end
            settled_q <= state_q == dot_pkg::DOT_CTL_RUN && settle_q == 8'h00 && odt_d == odt_q;
            pd_q <= ~cke_q;
        end
    end

    assign link.odt = odt_q;
    assign link.cke = cke_q;
    assign link.cmd = cmd_q;
    assign cmd_taken = taken_q;
    assign cmd_refused = refused_q;
    assign term_settled = settled_q;
    assign in_pd = pd_q;
endmodule

// ---- tb/dot_link_assertions.sv ----
// concurrent checks on the termination control link
`timescale 1ns/1ps
module dot_link_assertions #(
    parameter int WR_LATENCY = 7
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic odt,
    input wire logic cke,
    input var dot_pkg::dot_cmd_type cmd,
    input wire logic term_on,
    input wire logic ppd_dll_on,
    input wire logic term_uncertain,
    input wire logic async_mode,
    input wire logic hold_err
);
    localparam int LAT = WR_LATENCY - 2;
    logic [7:0] ref_age_q;
    // saturates so that a run without refresh never blocks the entry check
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ref_age_q <= 8'hff;
        end else if (cke && cmd == dot_pkg::DOT_CMD_REFRESH) begin
            ref_age_q <= 8'h00;
        end else if (ref_age_q != 8'hff) begin
            ref_age_q <= ref_age_q + 8'h01;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_sync;
        cke && !async_mode && !term_uncertain;
    endsequence
    sequence s_async;
        async_mode && $past(async_mode);
    endsequence
    sequence s_entry;
        $fell(cke) && !ppd_dll_on;
    endsequence
    AST_SYNC_ON: assert property (s_sync and $rose(odt) && !term_on |-> ##LAT !term_on ##1 term_on)
        else $error("sync turn-on latency wrong");
    AST_SYNC_OFF: assert property (s_sync and $fell(odt) && term_on |-> ##LAT term_on ##1 !term_on)
        else $error("sync turn-off latency wrong");
    AST_ASYNC_ON: assert property (s_async and $rose(odt) |-> !term_on ##1 !term_on ##1 term_on)
        else $error("async turn-on delay wrong");
    AST_ASYNC_OFF: assert property (s_async and $fell(odt) |-> term_on ##1 term_on ##1 !term_on)
        else $error("async turn-off delay wrong");
    AST_WR8_HOLD: assert property (odt && cke && cmd == dot_pkg::DOT_CMD_WRITE_BL8 |-> odt [*6])
        else $error("odt dropped early after eight-beat write");
    AST_BC4_HOLD: assert property (odt && cke && cmd == dot_pkg::DOT_CMD_WRITE_BC4 |-> odt [*4])
        else $error("odt dropped early after chopped write");
    AST_NO_HOLD_ERR: assert property (!hold_err)
        else $error("controller broke the minimum odt high time");
    AST_ENTRY: assert property (s_entry |-> ##1 term_uncertain ##[1:80] async_mode)
        else $error("entry transition not followed by async mode");
    AST_DLL_ON: assert property (ppd_dll_on |-> !term_uncertain && !async_mode)
        else $error("transition or async mode with dll kept on");
    AST_RFC: assert property ($rose(async_mode) |-> ref_age_q >= 8'h3f)
        else $error("async mode before refresh cycle time ended");
    AST_NO_RW_PD: assert property (!cke |-> !(cmd inside {dot_pkg::DOT_CMD_WRITE_BL8,
        dot_pkg::DOT_CMD_WRITE_BC4, dot_pkg::DOT_CMD_READ}))
        else $error("read or write issued in power-down");
endmodule

// ---- tb/ddr3_odt_async_transition_bench.sv ----
// self-checking bench for both ends of the termination control link
`timescale 1ns/1ps
`include "dot_defs.svh"
module ddr3_odt_async_transition_bench;
    localparam int WR_LATENCY = 7;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic ppd_dll_on = 1'b0;
    logic [`DOT_WRLAT_W-1:0] write_latency = 5'h07;
    logic odt_req, wr_req, wr_bc4, rd_req, ref_req, pd_req, seen;
    logic cmd_taken, cmd_refused, term_settled, in_pd, term_uncertain, async_mode, in_powerdown, hold_err;
    logic b_hold_err;
    int failures = 0;
    int n_tests = 0;
    int cyc = 0;
    int n, i;
    dot_pkg::dot_cmd_type cmds [5] = '{dot_pkg::DOT_CMD_NOP, dot_pkg::DOT_CMD_NOP, dot_pkg::DOT_CMD_WRITE_BL8,
        dot_pkg::DOT_CMD_WRITE_BL8, dot_pkg::DOT_CMD_WRITE_BC4};
    int highs [5] = '{3, 4, 5, 6, 4};
    logic [4:0] errs = 5'h05;
    dot_link_if lk ();
    dot_link_if lk_b ();
    dot_controller i_dot_controller (.core_clk(core_clk), .rst(rst), .ce(ce), .write_latency(write_latency),
        .link(lk.ctl), .odt_req(odt_req), .wr_req(wr_req), .wr_bc4(wr_bc4), .rd_req(rd_req), .ref_req(ref_req),
        .pd_req(pd_req), .cmd_taken(cmd_taken), .cmd_refused(cmd_refused), .term_settled(term_settled),
        .in_pd(in_pd));
    dot_device i_dot_device (.core_clk(core_clk), .rst(rst), .ce(ce), .ppd_dll_on(ppd_dll_on),
        .write_latency(write_latency), .link(lk.dev), .term_uncertain(term_uncertain), .async_mode(async_mode),
        .in_powerdown(in_powerdown), .hold_err(hold_err));
    // second device faces the bench so the controller never has to misbehave
    dot_device i_dot_device_b (.core_clk(core_clk), .rst(rst), .ce(ce), .ppd_dll_on(1'b1),
        .write_latency(write_latency), .link(lk_b.dev), .term_uncertain(), .async_mode(), .in_powerdown(),
        .hold_err(b_hold_err));
    dot_link_assertions #(.WR_LATENCY(WR_LATENCY)) i_dot_link_assertions (.core_clk(core_clk), .rst(rst), .odt(lk.odt),
        .cke(lk.cke), .cmd(lk.cmd), .term_on(lk.term_on), .ppd_dll_on(ppd_dll_on),
        .term_uncertain(term_uncertain), .async_mode(async_mode), .hold_err(hold_err));
    always #2.5 core_clk = ~core_clk;
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask
    task automatic check(input string what, input logic [7:0] seen_v, input logic [7:0] exp);
        n_tests++;
        if (seen_v !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen_v);
        end
    endtask
    task automatic wrap_up();
        if (failures == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic issue(input logic w, input logic b4, input logic r, input logic f, input logic [2:0] exp);
        wr_req = w;
        wr_bc4 = b4;
        rd_req = r;
        ref_req = f;
        tick();
        check("cmd_taken", cmd_taken, 8'h01);
        check("cmd", lk.cmd, exp);
    endtask
    task automatic sync_step(input logic v);
        odt_req = v;
        tick();
        repeat (WR_LATENCY - 2) tick();
        check("term_on_early", lk.term_on, !v);
        tick();
        check("term_on_sync", lk.term_on, v);
        repeat (4) tick();
    endtask
    // async answer lands one cycle after the device registers odt
    task automatic async_step(input logic v);
        odt_req = v;
        tick();
        tick();
        check("term_on_hold", lk.term_on, !v);
        tick();
        check("term_on_async", lk.term_on, v);
        repeat (4) tick();
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        {odt_req, wr_req, wr_bc4, rd_req, ref_req, pd_req} = 6'h00;
        lk_b.odt = 1'b0;
        lk_b.cke = 1'b0;
        lk_b.cmd = dot_pkg::DOT_CMD_NOP;
        repeat (3) tick();
        check("rst_odt", lk.odt, 8'h00);
        check("rst_term_on", lk.term_on, 8'h00);
        rst = 1'b0;
        lk_b.cke = 1'b1;
        repeat (3) tick();
        sync_step(1'b1);
        sync_step(1'b0);
        for (i = 0; i < 2; i++) begin
            odt_req = 1'b1;
            issue(1'b1, i[0], 1'b0, 1'b0, i[0] ? dot_pkg::DOT_CMD_WRITE_BC4 : dot_pkg::DOT_CMD_WRITE_BL8);
            odt_req = 1'b0;
            wr_req = 1'b0;
            for (n = 0; lk.odt === 1'b1 && n < 20; n++) tick();
            check("odt_hold", n >= (i[0] ? 4 : 6), 8'h01);
            repeat (12) tick();
        end
        issue(1'b0, 1'b0, 1'b1, 1'b0, dot_pkg::DOT_CMD_READ);
        issue(1'b0, 1'b0, 1'b0, 1'b1, dot_pkg::DOT_CMD_REFRESH);
        ref_req = 1'b0;
        check("settled", term_settled, 8'h01);
        pd_req = 1'b1;
        tick();
        rd_req = 1'b1;
        seen = 1'b0;
        for (n = 1; async_mode !== 1'b1 && n < 200; n++) begin
            if (term_uncertain === 1'b1) seen = 1'b1;
            tick();
        end
        check("refused", cmd_refused, 8'h01);
        check("uncertain_seen", seen, 8'h01);
        check("rfc_wait", n >= 63, 8'h01);
        check("cke_low", lk.cke, 8'h00);
        check("async_entered", async_mode, 8'h01);
        check("in_powerdown", in_powerdown, 8'h01);
        check("settled_pd", term_settled, 8'h00);
        async_step(1'b1);
        async_step(1'b0);
        rd_req = 1'b0;
        pd_req = 1'b0;
        for (n = 0; in_pd !== 1'b0 && n < 40; n++) tick();
        repeat (WR_LATENCY + 4) tick();
        check("exit_sync", async_mode, 8'h00);
        ppd_dll_on = 1'b1;
        pd_req = 1'b1;
        for (n = 0; in_pd !== 1'b1 && n < 40; n++) tick();
        check("in_pd", in_pd, 8'h01);
        repeat (8) tick();
        check("dll_on_async", async_mode, 8'h00);
        check("dll_on_powerdown", in_powerdown, 8'h01);
        pd_req = 1'b0;
        repeat (12) tick();
        // clock enable low must freeze the controller's odt flop
        ce = 1'b0;
        odt_req = 1'b1;
        repeat (3) tick();
        check("ce_freeze", lk.odt, 8'h00);
        odt_req = 1'b0;
        ce = 1'b1;
        repeat (2) tick();
        for (i = 0; i < 5; i++) begin
            lk_b.odt = 1'b1;
            lk_b.cmd = cmds[i];
            tick();
            lk_b.cmd = dot_pkg::DOT_CMD_NOP;
            repeat (highs[i] - 1) tick();
            lk_b.odt = 1'b0;
            seen = 1'b0;
            repeat (4) begin
                tick();
                if (b_hold_err === 1'b1) seen = 1'b1;
            end
            check("hold_err", seen, errs[i]);
            repeat (8) tick();
        end
        wrap_up();
    end
endmodule
